/* dacl_pkg.sv */
package dacl_pkg;

  // Converter and serializer widths
  localparam int unsigned DACL_ADC_BITS  = 12;  // Sample code width
  localparam int unsigned DACL_WORD_MAX  = 16;  // Widest serialized word
  localparam int unsigned DACL_CNT_W     = 5;   // Bit counter width

  // Bits per word for each serialization width, as sent on one lane
  localparam logic [4:0] DACL_BITS_16 = 5'h10;
  localparam logic [4:0] DACL_BITS_14 = 5'h0E;
  localparam logic [4:0] DACL_BITS_12 = 5'h0C;

  // Configuration port framing: read flag, 7-bit address, 8-bit data
  localparam logic [4:0] DACL_SPI_FRAME   = 5'h10;
  localparam logic [4:0] DACL_SPI_HDR     = 5'h08;
  localparam int unsigned DACL_RW_POS     = 15;
  localparam int unsigned DACL_NUM_REGS   = 2;

  // Configuration register addresses
  localparam logic [6:0] DACL_ADDR_POWER  = 7'h01;
  localparam logic [6:0] DACL_ADDR_OUTPUT = 7'h02;

  // Field positions inside the power register
  localparam int unsigned DACL_PWR_DOWN_POS = 0;
  localparam int unsigned DACL_PWR_TERM_POS = 1;
  // Field positions inside the output register
  localparam int unsigned DACL_OUT_SER_LSB  = 0;
  localparam int unsigned DACL_OUT_ONE_POS  = 2;
  localparam int unsigned DACL_OUT_DRV_POS  = 3;

  // Values after reset
  localparam logic [7:0] DACL_POWER_RST  = 8'h00;
  localparam logic [7:0] DACL_OUTPUT_RST = 8'h00;

  // Serialization width selection
  typedef enum logic [1:0] {
    DACL_SER16,
    DACL_SER14,
    DACL_SER12
  } dacl_ser_t;

  // Serializer sequencing
  typedef enum logic {
    DACL_IDLE,
    DACL_SHIFT
  } dacl_state_t;

  // Serial bits sent on one lane for a word
  function automatic logic [4:0] dacl_lane_bits(input dacl_ser_t ser,
                                                input logic      one_lane);
    logic [4:0] n;
    n = DACL_BITS_16;
    if (ser == DACL_SER14) begin
      n = DACL_BITS_14;
    end else if (ser == DACL_SER12) begin
      n = DACL_BITS_12;
    end
    return one_lane ? n : {1'b0, n[4:1]};
  endfunction

endpackage

/* dacl_cfg_if.sv */
`timescale 1ns/1ns
// Settings and synchronized pin levels between port logic and core
interface dacl_cfg_if;
  import dacl_pkg::*;
  logic      par_mode;    // Strap level, parallel configuration when high
  logic      cs_lvl;      // Synchronized chip select pin
  logic      sck_lvl;     // Synchronized shift clock pin
  logic      sdi_lvl;     // Synchronized data input pin
  logic      sdo_lvl;     // Synchronized readback pin as input
  dacl_ser_t ser;         // Serialization width
  logic      one_lane;    // One lane per channel
  logic      drive_low;   // Reduced driver current
  logic      power_down;  // Whole part powered down
  logic      term_en;     // Internal output termination

  modport cfg (input par_mode, output cs_lvl, output sck_lvl,
               output sdi_lvl, output sdo_lvl, output ser,
               output one_lane, output drive_low, output power_down,
               output term_en);
  modport core (output par_mode, input cs_lvl, input sck_lvl,
                input sdi_lvl, input sdo_lvl, input ser, input one_lane,
                input drive_low, input power_down, input term_en);
endinterface

/* dacl_cfg_port.sv */
`timescale 1ns/1ns
// Serial configuration port with open-drain readback
module dacl_cfg_port
  import dacl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic spi_cs_n,
  input  wire logic spi_sck,
  input  wire logic spi_sdi,
  input  wire logic spi_sdo_in,
  output logic      spi_sdo_out,
  output logic      spi_sdo_oe,
  dacl_cfg_if.cfg   cfg
);

  logic [3:0]  sync1_reg, sync2_reg;  // Two-stage pin synchronizers
  logic        sck_prev_reg;          // Last synchronized shift clock
  logic [15:0] sh_reg, sh_next;       // Incoming frame
  logic [4:0]  cnt_reg, cnt_next;     // Bits taken in this frame
  logic [7:0]  rd_reg, rd_next;       // Readback shifter
  logic        rd_act_reg, rd_act_next;
  logic        sdo_reg, sdo_next;     // Bit on readback pin
  logic [7:0]  regs_reg [DACL_NUM_REGS];
  logic [7:0]  regs_next [DACL_NUM_REGS];
  logic        sck_rise, sck_fall, sel;

  // Pin synchronizers; only the second stage is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg    <= 4'h0;
      sync2_reg    <= 4'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {spi_sdo_in, spi_sdi, spi_sck, spi_cs_n};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[1];
    end
  end

  assign cfg.cs_lvl  = sync2_reg[0];
  assign cfg.sck_lvl = sync2_reg[1];
  assign cfg.sdi_lvl = sync2_reg[2];
  assign cfg.sdo_lvl = sync2_reg[3];

  // Shift clock edges count only while selected in serial mode
  assign sel      = ~sync2_reg[0] & ~cfg.par_mode;
  assign sck_rise = sel & sync2_reg[1] & ~sck_prev_reg;
  assign sck_fall = sel & ~sync2_reg[1] & sck_prev_reg;

  // Frame decode, register write and readback sequencing
  always_comb begin
    sh_next     = sh_reg;
    cnt_next    = cnt_reg;
    rd_next     = rd_reg;
    rd_act_next = rd_act_reg;
    sdo_next    = sdo_reg;
    for (int i = 0; i < DACL_NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (!sel) begin
      // Deselect ends any frame; settings are kept
      cnt_next    = 5'h00;
      rd_act_next = 1'b0;
      sdo_next    = 1'b1;
    end else if (sck_rise && cnt_reg != DACL_SPI_FRAME) begin
      sh_next  = {sh_reg[14:0], sync2_reg[2]};
      cnt_next = cnt_reg + 5'h01;
      if (cnt_reg == DACL_SPI_FRAME - 5'h01 && !sh_reg[DACL_RW_POS - 1]) begin
        // Last bit of a write frame commits the byte
        if (sh_reg[13:7] == DACL_ADDR_POWER ||
            sh_reg[13:7] == DACL_ADDR_OUTPUT) begin
          regs_next[sh_reg[13:7] == DACL_ADDR_OUTPUT] =
            {sh_reg[6:0], sync2_reg[2]};
        end
      end
      if (cnt_reg == DACL_SPI_HDR - 5'h01) begin
        // Header complete; unmapped addresses read as zero
        rd_act_next = sh_reg[6];
        rd_next     = ({sh_reg[5:0], sync2_reg[2]} == DACL_ADDR_POWER ||
                       {sh_reg[5:0], sync2_reg[2]} == DACL_ADDR_OUTPUT) ?
                      regs_reg[{sh_reg[5:0], sync2_reg[2]} ==
                               DACL_ADDR_OUTPUT] : 8'h00;
      end
    end else if (sck_fall && rd_act_reg) begin
      // New readback bit after each falling edge, host takes the next one
      sdo_next = rd_reg[7];
      rd_next  = {rd_reg[6:0], 1'b0};
    end
  end

  // Port state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg      <= 16'h0000;
      cnt_reg     <= 5'h00;
      rd_reg      <= 8'h00;
      rd_act_reg  <= 1'b0;
      sdo_reg     <= 1'b1;
      regs_reg[0] <= DACL_POWER_RST;
      regs_reg[1] <= DACL_OUTPUT_RST;
    end else begin
      sh_reg     <= sh_next;
      cnt_reg    <= cnt_next;
      rd_reg     <= rd_next;
      rd_act_reg <= rd_act_next;
      sdo_reg    <= sdo_next;
      regs_reg   <= regs_next;
    end
  end

  // Open drain: only ever pulls low
  assign spi_sdo_out = 1'b0;
  assign spi_sdo_oe  = ~cfg.par_mode & rd_act_reg & ~sdo_reg;

  // Parallel mode takes settings straight from the pin levels; serialization is fixed at 16 bits
  always_comb begin
    if (cfg.par_mode) begin
      cfg.ser        = DACL_SER16;
      cfg.one_lane   = sync2_reg[0];
      cfg.drive_low  = sync2_reg[1];
      cfg.power_down = sync2_reg[2];
      cfg.term_en    = sync2_reg[3];
    end else begin
      cfg.ser        = (regs_reg[1][1:0] == 2'h1) ? DACL_SER14 :
                       (regs_reg[1][1:0] == 2'h2) ? DACL_SER12 : DACL_SER16;
      cfg.one_lane   = regs_reg[1][DACL_OUT_ONE_POS];
      cfg.drive_low  = regs_reg[1][DACL_OUT_DRV_POS];
      cfg.power_down = regs_reg[0][DACL_PWR_DOWN_POS];
      cfg.term_en    = regs_reg[0][DACL_PWR_TERM_POS];
    end
  end

endmodule

/* dacl_top.sv */
`timescale 1ns/1ns
// How it works
// - Filler pair after the code reads zero unless over range
// - Two-lane 14-bit frame spans two encode periods
// - One-lane mode disables B lanes, all on A
// - 16, 14, 12-bit serialization in both arrangements
// - Conversion starts on encode rising edge
// - Shift clock counts only with chip select low
// - Input data sampled on rising shift clock
// - Readback shifted out on open-drain pin
// - Parallel mode: chip select picks lane count
// - Parallel mode: shift clock picks drive current
// - Parallel mode: data input powers down part
// - Parallel mode: readback pin enables termination
module dacl_top
  import dacl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     config_mode_strap,
  input  wire logic                     sample_strobe_pos,
  input  wire logic                     sample_strobe_neg,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_sck,
  input  wire logic                     spi_sdi,
  input  wire logic                     spi_sdo_in,
  output logic                          spi_sdo_out,
  output logic                          spi_sdo_oe,
  input  wire logic [DACL_ADC_BITS-1:0] ch1_code,
  input  wire logic [DACL_ADC_BITS-1:0] ch2_code,
  input  wire logic                     ch1_over,
  input  wire logic                     ch2_over,
  output logic                          bit_clock_out,
  output logic                          word_start_marker,
  output logic                          lane_1a,
  output logic                          lane_1b,
  output logic                          lane_2a,
  output logic                          lane_2b,
  output logic                          lane_b_enable,
  output logic                          power_down,
  output logic                          drive_low,
  output logic                          term_enable
);

  dacl_cfg_if cfg_bus ();

  // Pin synchronizers for strap and encode inputs
  logic [2:0] psync1_reg, psync2_reg;
  logic       enc_prev_reg;         // Last encode level seen
  logic       enc_lvl, enc_rise;

  // Sample hold between encode edge and serializer
  logic [DACL_ADC_BITS-1:0] hold1_reg, hold1_next;
  logic [DACL_ADC_BITS-1:0] hold2_reg, hold2_next;
  logic                     hov1_reg, hov1_next;
  logic                     hov2_reg, hov2_next;
  logic                     pend_reg, pend_next;  // Sample waiting

  // Serializer state
  dacl_state_t              state_reg, state_next;
  logic [4:0]               cnt_reg, cnt_next;     // Lane bit index
  logic                     phase_reg, phase_next; // 0 data, 1 clock
  logic [DACL_WORD_MAX-1:0] w1_reg, w1_next;       // Channel 1 word
  logic [DACL_WORD_MAX-1:0] w2_reg, w2_next;       // Channel 2 word
  dacl_ser_t                ser_reg, ser_next;     // Active width
  logic                     one_reg, one_next;     // Active lane count
  logic                     pair_reg, pair_next;   // Mid 14-bit pair
  logic                     first_reg, first_next; // Word opens a pair
  logic [1:0]               la_reg, la_next;       // A lanes, ch2:ch1
  logic [1:0]               lb_reg, lb_next;       // B lanes, ch2:ch1
  logic                     bclk_reg, bclk_next;
  logic                     fr_reg, fr_next;

  // Scratch terms of the serializer
  logic [4:0] lane_bits, ia, ib;
  logic       pair14, load;
  dacl_ser_t  ld_ser;
  logic       ld_one;

  // Strap is caught through the same two-stage path as any pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psync1_reg   <= 3'h0;
      psync2_reg   <= 3'h0;
      enc_prev_reg <= 1'b0;
    end else begin
      psync1_reg   <= {config_mode_strap, sample_strobe_neg,
                       sample_strobe_pos};
      psync2_reg   <= psync1_reg;
      enc_prev_reg <= enc_lvl;
    end
  end

  // Strap is expected static; a toggle just flips the port mode
  assign cfg_bus.par_mode = psync2_reg[2];

  // Positive high with complement low; single-ended ties complement low
  assign enc_lvl  = psync2_reg[0] & ~psync2_reg[1];
  assign enc_rise = enc_lvl & ~enc_prev_reg;

  // Configuration port and parallel pin decode
  dacl_cfg_port u_cfg (
    .clk         (clk),
    .rst         (rst),
    .spi_cs_n    (spi_cs_n),
    .spi_sck     (spi_sck),
    .spi_sdi     (spi_sdi),
    .spi_sdo_in  (spi_sdo_in),
    .spi_sdo_out (spi_sdo_out),
    .spi_sdo_oe  (spi_sdo_oe),
    .cfg         (cfg_bus.cfg)
  );

  // Settings the analog side would consume
  assign power_down    = cfg_bus.power_down;
  assign drive_low     = cfg_bus.drive_low;
  assign term_enable   = cfg_bus.term_en;
  assign lane_b_enable = ~one_reg & ~cfg_bus.power_down;

  // Lane geometry of the word in flight
  assign lane_bits = dacl_lane_bits(ser_reg, one_reg);
  assign pair14    = (ser_reg == DACL_SER14) & ~one_reg;
  assign ia        = one_reg ? 5'(15 - cnt_reg) : 5'(15 - 2 * cnt_reg);
  assign ib        = 5'(14 - 2 * cnt_reg);

  // A word may start once a sample waits and the last word is done
  assign load = pend_reg & ~cfg_bus.power_down &
                ((state_reg == DACL_IDLE) ||
                 (phase_reg && cnt_reg == lane_bits - 5'h01));

  // Mid-pair words keep the active mode so no frame is split
  assign ld_ser = pair_reg ? ser_reg : cfg_bus.ser;
  assign ld_one = pair_reg ? one_reg : cfg_bus.one_lane;

  // Next values of hold and serializer state
  always_comb begin
    hold1_next = hold1_reg;
    hold2_next = hold2_reg;
    hov1_next  = hov1_reg;
    hov2_next  = hov2_reg;
    pend_next  = pend_reg;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    w1_next    = w1_reg;
    w2_next    = w2_reg;
    ser_next   = ser_reg;
    one_next   = one_reg;
    pair_next  = pair_reg;
    first_next = first_reg;
    la_next    = la_reg;
    lb_next    = lb_reg;
    bclk_next  = bclk_reg;
    fr_next    = fr_reg;
    if (load) begin
      // Hold is consumed; a coinciding encode edge refills it below
      pend_next = 1'b0;
    end
    if (enc_rise) begin
      // Capture both channels together at the encode edge
      hold1_next = ch1_code;
      hold2_next = ch2_code;
      hov1_next  = ch1_over;
      hov2_next  = ch2_over;
      pend_next  = 1'b1;
    end
    if (cfg_bus.power_down) begin
      // Powered down: lanes quiet, pairing restarts afterwards
      state_next = DACL_IDLE;
      pend_next  = 1'b0;
      pair_next  = 1'b0;
      la_next    = 2'b00;
      lb_next    = 2'b00;
      fr_next    = 1'b0;
    end else if (load) begin
      // Filler pair follows the code, zero unless over range
      w1_next    = {hold1_reg, hov1_reg, hov1_reg, 2'b00};
      w2_next    = {hold2_reg, hov2_reg, hov2_reg, 2'b00};
      if (ld_ser == DACL_SER12) begin
        w1_next = {hold1_reg, 4'h0};
        w2_next = {hold2_reg, 4'h0};
      end
      ser_next   = ld_ser;
      one_next   = ld_one;
      // Two-lane 14-bit words alternate, opening one pair per two samples
      pair_next  = (ld_ser == DACL_SER14 && !ld_one) ? ~pair_reg : 1'b0;
      first_next = ~pair_reg;
      cnt_next   = 5'h00;
      phase_next = 1'b0;
      bclk_next  = bclk_reg ^ (state_reg == DACL_SHIFT);  // Closing edge kept
      state_next = DACL_SHIFT;
    end else begin
      unique case (state_reg)
        DACL_IDLE: begin
          // Clock holds, since a park edge would read as a bit
          ser_next = ld_ser;
          one_next = ld_one;
        end
        DACL_SHIFT: begin
          phase_next = ~phase_reg;
          if (!phase_reg) begin
            // Data changes half a bit before the bit clock edge
            la_next = {w2_reg[ia[3:0]], w1_reg[ia[3:0]]};
            lb_next = one_reg ? 2'b00 :
                      {w2_reg[ib[3:0]], w1_reg[ib[3:0]]};
            fr_next = pair14 ? first_reg :
                      (cnt_reg < {1'b0, lane_bits[4:1]});
          end else begin
            // Each bit toggles the clock so both edges carry data
            bclk_next = ~bclk_reg;
            cnt_next  = cnt_reg + 5'h01;
            if (cnt_reg == lane_bits - 5'h01) begin
              state_next = DACL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Serializer and hold registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold1_reg <= '0;
      hold2_reg <= '0;
      hov1_reg  <= 1'b0;
      hov2_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      state_reg <= DACL_IDLE;
      cnt_reg   <= 5'h00;
      phase_reg <= 1'b0;
      w1_reg    <= 16'h0000;
      w2_reg    <= 16'h0000;
      ser_reg   <= DACL_SER16;
      one_reg   <= 1'b0;
      pair_reg  <= 1'b0;
      first_reg <= 1'b0;
      la_reg    <= 2'b00;
      lb_reg    <= 2'b00;
      bclk_reg  <= 1'b0;
      fr_reg    <= 1'b0;
    end else begin
      hold1_reg <= hold1_next;
      hold2_reg <= hold2_next;
      hov1_reg  <= hov1_next;
      hov2_reg  <= hov2_next;
      pend_reg  <= pend_next;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      w1_reg    <= w1_next;
      w2_reg    <= w2_next;
      ser_reg   <= ser_next;
      one_reg   <= one_next;
      pair_reg  <= pair_next;
      first_reg <= first_next;
      la_reg    <= la_next;
      lb_reg    <= lb_next;
      bclk_reg  <= bclk_next;
      fr_reg    <= fr_next;
    end
  end

  // Lane pins straight from flops; receiver samples on both edges
  assign lane_1a           = la_reg[0];
  assign lane_2a           = la_reg[1];
  assign lane_1b           = lb_reg[0];
  assign lane_2b           = lb_reg[1];
  assign bit_clock_out     = bclk_reg;
  assign word_start_marker = fr_reg;

endmodule

/* dacl_top_props.sv */
`timescale 1ns/1ns
// Port-level checks on configuration pins and the lane stream
module dacl_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic config_mode_strap,
  input wire logic sample_strobe_pos,
  input wire logic sample_strobe_neg,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  input wire logic spi_sdo_in,
  input wire logic spi_sdo_out,
  input wire logic spi_sdo_oe,
  input wire logic bit_clock_out,
  input wire logic word_start_marker,
  input wire logic lane_1a,
  input wire logic lane_1b,
  input wire logic lane_2b,
  input wire logic lane_b_enable,
  input wire logic power_down,
  input wire logic drive_low,
  input wire logic term_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic       bclk_reg;   // Bit clock one cycle back
  logic [3:0] quiet_reg;  // Cycles since the bit clock moved
  logic [3:0] quiet_next;

  // Idle detector; saturates since only long quiet matters
  always_comb begin
    quiet_next = quiet_reg + 4'h1;
    if (bit_clock_out != bclk_reg) begin
      quiet_next = 4'h0;
    end else if (quiet_reg == 4'hF) begin
      quiet_next = 4'hF;
    end
  end

  // Helper registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_reg  <= 1'b0;
      quiet_reg <= 4'h0;
    end else begin
      bclk_reg  <= bit_clock_out;
      quiet_reg <= quiet_next;
    end
  end

  // Encode rises, complement low, converter idle and powered
  sequence enc_edge_s;
    $rose(sample_strobe_pos) && !sample_strobe_neg && quiet_reg == 4'hF
      && !power_down;
  endsequence
  // Lane stream starts moving a few clocks later
  sequence lane_start_s;
    ##[4:10] $changed(bit_clock_out);
  endsequence

  enc_start_a: assert property (enc_edge_s |-> lane_start_s)
    else $error("No word after encode edge");
  b_lanes_off_a: assert property (
    !lane_b_enable && bit_clock_out != bclk_reg |-> !lane_1b && !lane_2b)
    else $error("B lane busy in one-lane mode");
  bit_centre_a: assert property (
    $changed(bit_clock_out) |-> $stable(lane_1a) && $stable(lane_1b)
      && $stable(word_start_marker))
    else $error("Lane data moved with bit clock");
  pd_lanes_off_a: assert property (power_down |-> !lane_b_enable)
    else $error("B lanes on while powered down");
  sdo_low_a: assert property (spi_sdo_out == 1'b0)
    else $error("Readback pin driven high");
  cs_idle_oe_a: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
    else $error("Readback active while deselected");
  par_lanes_a: assert property (
    (config_mode_strap && spi_cs_n) [*8] |-> !lane_b_enable)
    else $error("Parallel one-lane pin ignored");
  par_drive_a: assert property (
    (config_mode_strap && spi_sck) [*8] |-> drive_low)
    else $error("Parallel drive pin ignored");
  par_power_a: assert property (
    (config_mode_strap && spi_sdi) [*8] |-> power_down)
    else $error("Parallel power pin ignored");
  par_term_a: assert property (
    (config_mode_strap && spi_sdo_in) [*8] |-> term_enable)
    else $error("Parallel termination pin ignored");
endmodule

bind dacl_top dacl_top_props u_props (
  .clk(clk), .rst(rst), .config_mode_strap(config_mode_strap),
  .sample_strobe_pos(sample_strobe_pos),
  .sample_strobe_neg(sample_strobe_neg), .spi_cs_n(spi_cs_n),
  .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_in(spi_sdo_in),
  .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe),
  .bit_clock_out(bit_clock_out), .word_start_marker(word_start_marker),
  .lane_1a(lane_1a), .lane_1b(lane_1b), .lane_2b(lane_2b),
  .lane_b_enable(lane_b_enable), .power_down(power_down),
  .drive_low(drive_low), .term_enable(term_enable)
);

/* dacl_rx_model.sv */
`timescale 1ns/1ns
// Lane receiver: a bit on either bit clock edge, framed by marker
module dacl_rx_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bclk,   // Bit clock from the converter
  input  wire logic        mark,   // Word start marker
  input  wire logic [3:0]  lanes,  // Lanes 1A, 1B, 2A, 2B
  input  wire logic        one,    // One lane per channel
  input  wire logic [4:0]  nbits,  // Lane bits in one word
  output logic      [15:0] word1,  // Last channel 1 word
  output logic      [15:0] word2,  // Last channel 2 word
  output logic             vld     // Pulse on a finished word
);
  logic        bclk_reg;   // Bit clock as last seen
  logic        mark_reg;   // Marker at the previous bit
  logic        mark_next;
  logic [4:0]  cnt_reg;    // Bits taken in this word
  logic [4:0]  cnt_next;
  logic [15:0] w1_next;
  logic [15:0] w2_next;
  logic        vld_next;
  logic        start;      // This bit opens a word

  // Marker rise or a finished count opens the next word
  always_comb begin
    cnt_next  = cnt_reg;
    mark_next = mark_reg;
    w1_next   = word1;
    w2_next   = word2;
    vld_next  = 1'b0;
    start     = (mark && !mark_reg) || cnt_reg == 5'h00;
    if (bclk != bclk_reg) begin
      mark_next = mark;
      w1_next = one ? {(start ? 15'h0 : word1[14:0]), lanes[3]}
                    : {(start ? 14'h0 : word1[13:0]), lanes[3:2]};
      w2_next = one ? {(start ? 15'h0 : word2[14:0]), lanes[1]}
                    : {(start ? 14'h0 : word2[13:0]), lanes[1:0]};
      cnt_next = start ? 5'h01 : cnt_reg + 5'h01;
      if (cnt_next == nbits) begin
        cnt_next = 5'h00;
        vld_next = 1'b1;
      end
    end
  end

  // Receiver state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {bclk_reg, mark_reg, vld} <= 3'h0;
      cnt_reg <= 5'h00;
      word1   <= 16'h0000;
      word2   <= 16'h0000;
    end else begin
      bclk_reg <= bclk;
      mark_reg <= mark_next;
      vld      <= vld_next;
      cnt_reg  <= cnt_next;
      word1    <= w1_next;
      word2    <= w2_next;
    end
  end
endmodule

/* test_dual_adc_config_and_lane_output.sv */
`timescale 1ns/1ns
// Lane formats, register readback and parallel strap pins
module test_dual_adc_config_and_lane_output;
  import dacl_pkg::*;

  logic        clk, rst, strap, enc_p, enc_n, ov1, ov2;
  logic        spi_cs_n, spi_sck, spi_sdi, sdo_pin, sdo_oe, sdo_out;
  logic [11:0] code1, code2;
  logic        bclk, mark, l1a, l1b, l2a, l2b, lb_en, pd, drv, term;
  logic        rx_one, rx_vld, mark_d;
  logic [4:0]  rx_nbits, nb;
  logic [15:0] rx_w1, rx_w2;
  logic [7:0]  q;
  logic [63:0] row;
  int          err_total, checks, rises;
  wire         sdo_line = sdo_oe ? 1'b0 : sdo_pin; // Pull-up wire

  // Mode, code1, over1, word1, code2, word2
  logic [63:0] rows [6] = '{64'h0_A5C_1_A5CC_3F0_3F00,
    64'h1_123_0_1230_FFF_FFF0, 64'h2_801_1_2007_7FE_1FF8,
    64'h3_555_0_1554_AAA_2AA8, 64'h4_F0F_1_0F0F_0F0_00F0,
    64'h5_C33_0_0C33_3CC_03CC};

  dacl_top u_dacl_top (.clk(clk), .rst(rst), .config_mode_strap(strap),
    .sample_strobe_pos(enc_p), .sample_strobe_neg(enc_n),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
    .spi_sdo_in(sdo_line), .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe),
    .ch1_code(code1), .ch2_code(code2), .ch1_over(ov1), .ch2_over(ov2),
    .bit_clock_out(bclk), .word_start_marker(mark), .lane_1a(l1a),
    .lane_1b(l1b), .lane_2a(l2a), .lane_2b(l2b), .lane_b_enable(lb_en),
    .power_down(pd), .drive_low(drv), .term_enable(term));

  dacl_rx_model u_dacl_rx_model (.clk(clk), .rst(rst), .bclk(bclk),
    .mark(mark), .lanes({l1a, l1b, l2a, l2b}), .one(rx_one),
    .nbits(rx_nbits), .word1(rx_w1), .word2(rx_w2), .vld(rx_vld));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Marker rises, to tell one word per frame from two
  always @(posedge clk) begin
    mark_d <= mark;
    if (mark && !mark_d) begin
      rises <= rises + 1;
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One frame at the link rate; readback taken before each of the last eight falls
  task automatic spi(input logic sel, input logic [15:0] f,
                     output logic [7:0] d);
    d = 8'h00;
    spi_cs_n = !sel;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      #40 spi_sck = 1'b1;
      #40;
      if (i < 8) begin
        d[i] = sdo_line;
      end
      spi_sck = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Encode pulse, then a bounded wait for the finished words
  task automatic sample(input logic [15:0] e1, input logic [15:0] e2,
                        input logic want);
    enc_p = 1'b1;
    for (int n = 0; n < 60 && rx_vld !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (n == 8) begin
        enc_p = 1'b0;
      end
    end
    enc_p = 1'b0;
    chk({15'h0, rx_vld === 1'b1}, {15'h0, want});
    if (want) begin
      chk(rx_w1, e1);
      chk(rx_w2, e2);
    end
    if (want && rx_vld !== 1'b1) begin
      end_of_test();
    end
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic s);
    rst = 1'b1;
    strap = s;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial begin
    {rst, enc_p, enc_n, spi_sck, spi_sdi, ov1, ov2, rx_one} = '0;
    {spi_cs_n, sdo_pin, strap} = 3'b110;
    {code1, code2, rises, err_total, checks} = '0;
    rx_nbits = 5'h08;
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      row = rows[i];
      spi(1'b1, {8'h02, 5'h00, row[60], row[62:61]}, q);
      nb = 5'h10 - {2'b00, row[62:61], 1'b0};
      rx_one = row[60];
      rx_nbits = row[60] ? nb : nb >> 1;
      {code1, ov1, code2} = {row[59:48], row[44], row[27:16]};
      rises = 0;
      sample(row[43:28], row[15:0], 1'b1);
      sample(row[43:28], row[15:0], 1'b1);
      chk(16'(rises), row[63:60] == 4'h2 ? 16'h1 : 16'h2);
      chk({15'h0, lb_en}, {15'h0, !row[60]});
    end
    do_reset(1'b0);
    chk({12'h0, lb_en, drv, pd, term}, 16'h0008);
    spi(1'b1, 16'h8200, q);
    chk({8'h00, q}, 16'h0000);
    spi(1'b1, 16'h0209, q);
    spi(1'b1, 16'h8200, q);
    chk({8'h00, q}, 16'h0009);
    spi(1'b0, 16'h0200, q);
    spi(1'b1, 16'h8200, q);
    chk({8'h00, q}, 16'h0009);
    spi(1'b1, 16'h8500, q);
    chk({8'h00, q}, 16'h0000);
    spi(1'b1, 16'h0103, q);
    chk({12'h0, lb_en, drv, pd, term}, 16'h0007);
    sample(16'h0000, 16'h0000, 1'b0);
    do_reset(1'b1);
    for (int k = 0; k < 16; k++) begin
      {spi_cs_n, spi_sdi, spi_sck, sdo_pin} = 4'(k);
      repeat (10) @(posedge clk);
      #1;
      chk({12'h0, lb_en, drv, pd, term},
          {12'h0, !k[3] && !k[2], k[1], k[2], k[0]});
    end
    end_of_test();
  end
endmodule
